// ==== rtl/cicic_chain.v ====
// What this block does
// - Coefficient-filter I and Q samples go through the fifth-order interpolator, then the resampler, then one shared scaler.
// - The shift amount is one unsigned programmable integer, meant to lie between 4 and 32, scaling both stages together.
// - Net gain is the fifth-order factor to the fourth, times the resampler interpolation factor, times two to the minus shift amount.
// - Each channel holds the fifth-order factor minus one at location fifth_order_interp_factor_minus_one, and that factor alone sets its response.
// - The fifth-order stage emits as many output samples per input sample as its interpolation factor.
// - The fifth-order stage is five cascaded comb and integrator sections, each comb spanning one input sample.
// - Each channel holds the shift amount at location cic_shift_select.
// - The shift amount picks the bit slice passed to the NCO stage, each step worth 6 dB.
// - The resampler runs at no clock faster than its output rate, its response set by its two factors.
// - The resampler changes rate by its interpolation factor over its decimation factor, allowing non-integer ratios.
// - Each channel holds resampler decimation minus one in 9 bits at 0xn07 and interpolation minus one in 12 bits at 0xn08.
// - The resampler acts as zero-stuffing by L then a second-order integrator-comb filter, and is a bypass when L and M are one.
`timescale 1ns/1ps
`include "cicic_regs.vh"

module cicic_chain #(
  parameter DW = 18,
  parameter C5W = DW + 25,
  parameter R2W = C5W + 14
) (
  input wire clk,
  input wire sys_rst,
  input wire [`CICIC_W_ADDR-1:0] reg_addr,
  input wire [`CICIC_W_DATA-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [`CICIC_W_DATA-1:0] reg_rdata,
  input wire [DW-1:0] in_i,
  input wire [DW-1:0] in_q,
  input wire in_valid,
  output wire in_ready,
  output wire [DW-1:0] out_i,
  output wire [DW-1:0] out_q,
  output wire out_valid,
  input wire out_ready
);

  // Control registers
  reg [`CICIC_W_SHIFT-1:0] shift_reg;
  reg [`CICIC_W_C5-1:0] c5_lm1_reg;
  reg [`CICIC_W_R2_DECIM-1:0] r2_mm1_reg;
  reg [`CICIC_W_R2_INTERP-1:0] r2_lm1_reg;
  reg [`CICIC_W_DATA-1:0] rdata_reg;

  // Sequencing state
  reg [`CICIC_W_C5-1:0] c5_cnt_reg;
  reg [`CICIC_W_R2_INTERP-1:0] r2_ph_reg;
  reg out_valid_reg;

  // Derived control
  wire [`CICIC_W_R2_INTERP:0] r2_l;
  wire [`CICIC_W_R2_INTERP:0] r2_m;
  wire [`CICIC_W_R2_INTERP:0] r2_dist;
  wire [`CICIC_W_R2_INTERP:0] r2_ph_sum;
  wire [`CICIC_W_R2_INTERP:0] r2_ph_wrap;
  wire [`CICIC_W_R2_INTERP-1:0] r2_ph_next;
  wire [`CICIC_W_C5-1:0] c5_cnt_next;

  // Handshake and advance strobes
  wire r2_cross;
  wire out_slot;
  wire c5_avail;
  wire c5_first;
  wire r2_fire;
  wire c5_adv;
  wire in_take;

  // Lane outputs gathered for the ports
  wire [2*DW-1:0] lane_pack;

  // Register writes
  always @(posedge clk) begin
    if (sys_rst) begin
      shift_reg <= `CICIC_RST_SHIFT;
      c5_lm1_reg <= `CICIC_RST_C5;
      r2_mm1_reg <= `CICIC_RST_R2_DECIM;
      r2_lm1_reg <= `CICIC_RST_R2_INTERP;
    end else if (reg_wr) begin
      case (reg_addr)
        `CICIC_ADDR_SHIFT: begin
          shift_reg <= reg_wdata[`CICIC_W_SHIFT-1:0];
        end
        `CICIC_ADDR_R2_DECIM: begin
          r2_mm1_reg <= reg_wdata[`CICIC_W_R2_DECIM-1:0];
        end
        `CICIC_ADDR_R2_INTERP: begin
          r2_lm1_reg <= reg_wdata[`CICIC_W_R2_INTERP-1:0];
        end
        `CICIC_ADDR_C5_INTERP: begin
          c5_lm1_reg <= reg_wdata[`CICIC_W_C5-1:0];
        end
        default: begin
          // Unmapped locations leave every field alone
          shift_reg <= shift_reg;
        end
      endcase
    end
  end

  // Register readback, one cycle after the read strobe
  always @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= {`CICIC_W_DATA{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `CICIC_ADDR_SHIFT: begin
          // Unused upper bits read as zero
          rdata_reg <= {{(`CICIC_W_DATA-`CICIC_W_SHIFT){1'b0}}, shift_reg};
        end
        `CICIC_ADDR_R2_DECIM: begin
          rdata_reg <= {{(`CICIC_W_DATA-`CICIC_W_R2_DECIM){1'b0}}, r2_mm1_reg};
        end
        `CICIC_ADDR_R2_INTERP: begin
          rdata_reg <= r2_lm1_reg;
        end
        `CICIC_ADDR_C5_INTERP: begin
          rdata_reg <= {{(`CICIC_W_DATA-`CICIC_W_C5){1'b0}}, c5_lm1_reg};
        end
        default: begin
          rdata_reg <= {`CICIC_W_DATA{1'b0}};
        end
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

  // The phase counts high-rate ticks modulo L; each output clock moves it on by M.
  // M above L is unsupported: one clock would then need more than one new input.
  // Factors changed mid-stream keep the old state; reset after reprogramming.

  // Resampler phase: distance to the next stuffed input and the crossing test
  assign r2_l = {1'b0, r2_lm1_reg} + 13'h0001;
  assign r2_m = {4'h0, r2_mm1_reg} + 13'h0001;
  assign r2_dist = (r2_ph_reg == {`CICIC_W_R2_INTERP{1'b0}}) ?
                   13'h0000 :
                   (r2_l - {1'b0, r2_ph_reg});
  assign r2_cross = (r2_dist < r2_m);
  assign r2_ph_sum = {1'b0, r2_ph_reg} + r2_m;
  assign r2_ph_wrap = (r2_ph_sum >= r2_l) ? (r2_ph_sum - r2_l) : r2_ph_sum;
  assign r2_ph_next = r2_ph_wrap[`CICIC_W_R2_INTERP-1:0];

  // Flow control: one resampler output per clock at most
  assign out_slot = !out_valid_reg || out_ready;
  assign c5_first = (c5_cnt_reg == {`CICIC_W_C5{1'b0}});
  assign c5_avail = !c5_first || in_valid;
  assign r2_fire = out_slot && (!r2_cross || c5_avail);
  assign c5_adv = r2_fire && r2_cross;
  assign in_ready = out_slot && r2_cross && c5_first;
  assign in_take = c5_adv && c5_first;

  // Fifth-order phase counter wraps at the programmed factor
  assign c5_cnt_next = (c5_cnt_reg == c5_lm1_reg) ? {`CICIC_W_C5{1'b0}} : (c5_cnt_reg + 8'h01);

  // Sequencing counters and output valid
  always @(posedge clk) begin
    if (sys_rst) begin
      c5_cnt_reg <= {`CICIC_W_C5{1'b0}};
      r2_ph_reg <= {`CICIC_W_R2_INTERP{1'b0}};
      out_valid_reg <= 1'b0;
    end else begin
      if (c5_adv) begin
        c5_cnt_reg <= c5_cnt_next;
      end

      if (r2_fire) begin
        r2_ph_reg <= r2_ph_next;
      end

      // Valid rises with each new sample and drops once the sample is taken
      if (r2_fire) begin
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  // Two identical lanes, I then Q
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      wire [DW-1:0] x_raw;
      reg signed [C5W-1:0] c5_dly_reg [0:`CICIC_C5_ORDER-1];
      reg signed [C5W-1:0] c5_int_reg [0:`CICIC_C5_ORDER-1];
      reg signed [C5W-1:0] c5_comb [0:`CICIC_C5_ORDER];
      reg signed [C5W-1:0] c5_int_next [0:`CICIC_C5_ORDER-1];
      reg signed [C5W-1:0] c5_stuff;

      // Resampler lane state
      reg signed [R2W-1:0] r2_d1_reg;
      reg signed [R2W-1:0] r2_d2_reg;
      reg signed [R2W-1:0] r2_acc1_reg;
      reg signed [R2W-1:0] r2_acc2_reg;
      reg [DW-1:0] out_reg;

      // Resampler lane nets
      wire signed [R2W-1:0] r2_in;
      wire signed [R2W-1:0] r2_e1;
      wire signed [R2W-1:0] r2_e2;
      wire signed [R2W-1:0] r2_acc1_next;
      wire signed [R2W+13:0] r2_prod_a;
      wire signed [R2W+13:0] r2_prod_b;
      wire signed [R2W+13:0] r2_prod_c;
      wire signed [R2W-1:0] r2_acc2_next;
      wire signed [R2W-1:0] r2_scaled;

      // Separate loop indices keep the combinational and clocked loops apart
      integer k;
      integer j;

      assign x_raw = (g == 0) ? in_i : in_q;

      // Fifth-order stage: five combs at the input rate, zero stuffing, five integrators
      always @* begin
        c5_comb[0] = {{(C5W-DW){x_raw[DW-1]}}, x_raw};
        for (k = 0; k < `CICIC_C5_ORDER; k = k + 1) begin
          c5_comb[k+1] = c5_comb[k] - c5_dly_reg[k];
        end
        c5_stuff = c5_first ? c5_comb[`CICIC_C5_ORDER] : {C5W{1'b0}};
        c5_int_next[0] = c5_int_reg[0] + c5_stuff;
        for (k = 1; k < `CICIC_C5_ORDER; k = k + 1) begin
          c5_int_next[k] = c5_int_reg[k] + c5_int_next[k-1];
        end
      end

      // Fifth-order state: combs advanced per input taken, integrators per sample handed to the resampler
      always @(posedge clk) begin
        if (sys_rst) begin
          for (j = 0; j < `CICIC_C5_ORDER; j = j + 1) begin
            c5_dly_reg[j] <= {C5W{1'b0}};
            c5_int_reg[j] <= {C5W{1'b0}};
          end
        end else begin
          for (j = 0; j < `CICIC_C5_ORDER; j = j + 1) begin
            // Comb delays move only when a new input is taken
            if (in_take) begin
              c5_dly_reg[j] <= c5_comb[j];
            end

            // Integrators move once per high-rate sample
            if (c5_adv) begin
              c5_int_reg[j] <= c5_int_next[j];
            end
          end
        end
      end

      // Resampler: two combs per input, first integrator holds across the stuffed zeros
      assign r2_in = {{(R2W-C5W){c5_int_next[`CICIC_C5_ORDER-1][C5W-1]}}, c5_int_next[`CICIC_C5_ORDER-1]};
      assign r2_e1 = r2_in - r2_d1_reg;
      assign r2_e2 = r2_e1 - r2_d2_reg;
      assign r2_acc1_next = r2_acc1_reg + r2_e2;

      // Second integrator advanced M high-rate ticks in one clock
      // Before the crossing the old first-integrator value counts, after it the new one
      assign r2_prod_a = r2_acc1_reg * $signed({1'b0, r2_dist});
      assign r2_prod_b = r2_acc1_next * $signed({1'b0, r2_m - r2_dist});
      assign r2_prod_c = r2_acc1_reg * $signed({1'b0, r2_m});
      assign r2_acc2_next = r2_acc2_reg + (r2_cross ? (r2_prod_a[R2W-1:0] + r2_prod_b[R2W-1:0])
                                                    : r2_prod_c[R2W-1:0]);

      // Shared scaler: arithmetic shift frames the bit slice, 6 dB a step
      // Low bits are kept without clipping, so too small a shift wraps
      assign r2_scaled = r2_acc2_next >>> shift_reg;

      // Resampler state and lane output
      always @(posedge clk) begin
        if (sys_rst) begin
          r2_d1_reg <= {R2W{1'b0}};
          r2_d2_reg <= {R2W{1'b0}};
          r2_acc1_reg <= {R2W{1'b0}};
          r2_acc2_reg <= {R2W{1'b0}};
          out_reg <= {DW{1'b0}};
        end else begin
          // Comb delays and first integrator move with each consumed sample
          if (c5_adv) begin
            r2_d1_reg <= r2_in;
            r2_d2_reg <= r2_e1;
            r2_acc1_reg <= r2_acc1_next;
          end

          // Second integrator and output move with each produced sample
          if (r2_fire) begin
            r2_acc2_reg <= r2_acc2_next;
            out_reg <= r2_scaled[DW-1:0];
          end
        end
      end

      assign lane_pack[g*DW +: DW] = out_reg;
    end
  endgenerate

  // Lane and valid outputs, all straight from flip-flops
  assign out_i = lane_pack[DW-1:0];
  assign out_q = lane_pack[2*DW-1:DW];
  assign out_valid = out_valid_reg;

endmodule // cicic_chain

// ==== rtl/cicic_regs.vh ====
`ifndef CICIC_REGS_VH
`define CICIC_REGS_VH

// Channel control locations, low nibble of the 0xn0X address
`define CICIC_ADDR_SHIFT 4'h6
`define CICIC_ADDR_R2_DECIM 4'h7
`define CICIC_ADDR_R2_INTERP 4'h8
`define CICIC_ADDR_C5_INTERP 4'h9

// Field widths
`define CICIC_W_ADDR 4
`define CICIC_W_DATA 12
`define CICIC_W_SHIFT 6
`define CICIC_W_C5 8
`define CICIC_W_R2_DECIM 9
`define CICIC_W_R2_INTERP 12

// Reset values: all factors one, smallest documented shift
`define CICIC_RST_SHIFT 6'h04
`define CICIC_RST_C5 8'h00
`define CICIC_RST_R2_DECIM 9'h000
`define CICIC_RST_R2_INTERP 12'h000

// Filter orders
`define CICIC_C5_ORDER 5
`define CICIC_R2_ORDER 2

`endif

// ==== tb/cicic_nco_model.sv ====
`timescale 1ns/1ps
module cicic_nco_model (
  input wire clk,
  input wire sys_rst,
  input wire stall_en,
  output reg out_ready
);
  initial out_ready = 1'b0;
  // Downstream accept, with random back-pressure when stalling is on
  always @(posedge clk) begin
    out_ready <= !sys_rst && (!stall_en || ($urandom % 3 != 0));
  end
endmodule // cicic_nco_model

// ==== tb/cicic_chain_sva.sv ====
`timescale 1ns/1ps
module cicic_chain_sva #(parameter DW = 18) (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] reg_addr,
  input wire [11:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_rdata,
  input wire [DW-1:0] in_i,
  input wire [DW-1:0] in_q,
  input wire in_valid,
  input wire in_ready,
  input wire [DW-1:0] out_i,
  input wire [DW-1:0] out_q,
  input wire out_valid,
  input wire out_ready
);
  reg [5:0] sh_reg;
  reg [8:0] dm_reg;
  reg [11:0] im_reg;
  reg [7:0] c5_reg;
  // Shadow copy of the control locations
  always @(posedge clk) begin
    if (sys_rst) begin
      sh_reg <= 6'h04;
      dm_reg <= 9'h000;
      im_reg <= 12'h000;
      c5_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 4'h6) sh_reg <= reg_wdata[5:0];
      if (reg_addr == 4'h7) dm_reg <= reg_wdata[8:0];
      if (reg_addr == 4'h8) im_reg <= reg_wdata;
      if (reg_addr == 4'h9) c5_reg <= reg_wdata[7:0];
    end
  end
  // Expected readback and bypass output
  wire [11:0] exp_rd = reg_addr == 4'h6 ? {6'h00, sh_reg} : reg_addr == 4'h7 ? {3'h0, dm_reg} :
    reg_addr == 4'h8 ? im_reg : reg_addr == 4'h9 ? {4'h0, c5_reg} : 12'h000;
  wire bypass = c5_reg == 8'h00 && dm_reg == 9'h000 && im_reg == 12'h000;
  wire take = in_valid && in_ready;
  wire [DW-1:0] exp_i = $signed(in_i) >>> sh_reg;
  wire [DW-1:0] exp_q = $signed(in_q) >>> sh_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_map_check_a: assert property (reg_rd |=> reg_rdata == $past(exp_rd))
    else $error("readback differs from written field");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("readback changed without a read");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_i) && $stable(out_q))
    else $error("stalled output changed");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !out_valid && out_i == 0 && reg_rdata == 0)
    else $error("reset did not clear outputs");
  bypass_ready_a: assert property (bypass && out_ready |-> in_ready)
    else $error("bypass refused a sample");
  bypass_take_a: assert property (bypass && take |=> out_valid)
    else $error("bypass take gave no output");
  bypass_gain_a: assert property (bypass && take |=> out_i == $past(exp_i) && out_q == $past(exp_q))
    else $error("bypass output not scaled input");
  interp_gap_a: assert property ((c5_reg != 0 || im_reg != 0) && dm_reg == 0 && take |=> !in_ready)
    else $error("input taken while still interpolating");
  cover property (bypass && take);
  cover property (out_valid && !out_ready);
  cover property (c5_reg != 0 && out_valid && out_ready);
endmodule // cicic_chain_sva
bind cicic_chain cicic_chain_sva #(.DW(DW)) chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_i(in_i), .in_q(in_q),
  .in_valid(in_valid), .in_ready(in_ready), .out_i(out_i), .out_q(out_q), .out_valid(out_valid),
  .out_ready(out_ready));

// ==== tb/tb_cicic_chain.sv ====
`timescale 1ns/1ps
module tb_cicic_chain;
  localparam DW = 18;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [11:0] reg_wdata = 12'h000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [DW-1:0] in_i = 18'h0_0000;
  reg [DW-1:0] in_q = 18'h0_0000;
  reg in_valid = 1'b0;
  reg stall_en = 1'b0;
  reg sb_on = 1'b0;
  reg [5:0] sh = 6'h04;
  reg [DW-1:0] last_i = 18'h0_0000;
  reg [2*DW-1:0] exp_q[$];
  wire [11:0] reg_rdata;
  wire in_ready;
  wire out_valid;
  wire out_ready;
  wire [DW-1:0] out_i;
  wire [DW-1:0] out_q;
  integer fail_count = 0;
  integer cmp_count = 0;
  integer takes = 0;
  integer outs = 0;
  integer a;
  cicic_chain dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_i(in_i), .in_q(in_q), .in_valid(in_valid), .in_ready(in_ready),
    .out_i(out_i), .out_q(out_q), .out_valid(out_valid), .out_ready(out_ready));
  cicic_nco_model nco_u (.clk(clk), .sys_rst(sys_rst), .stall_en(stall_en), .out_ready(out_ready));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task check(input [95:0] what, input [2*DW-1:0] exp, input [2*DW-1:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task rst(input integer n);
    begin
      sys_rst <= 1'b1;
      repeat (n) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wr(input [3:0] ad, input [11:0] d);
    begin
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd_chk(input [3:0] ad, input [11:0] e);
    begin
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      repeat (2) @(posedge clk);
      check("reg_rdata", e, reg_rdata);
    end
  endtask
  function [11:0] msk(input [3:0] ad);
    msk = ad == 4'h6 ? 12'h03f : ad == 4'h7 ? 12'h1ff : ad == 4'h8 ? 12'hfff : ad == 4'h9 ? 12'h0ff : 12'h000;
  endfunction
  // Upstream driver: notes the expected output of every taken sample while sb_on is set
  task stream(input integer n, input dc, input [DW-1:0] x);
    begin
      takes = 0;
      in_i <= dc ? x : $urandom;
      in_q <= dc ? -x : $urandom;
      in_valid <= 1'b1;
      while (takes < n) begin
        @(posedge clk);
        if (in_valid && in_ready) begin
          takes = takes + 1;
          if (sb_on) exp_q.push_back({$signed(in_i) >>> sh, $signed(in_q) >>> sh});
          in_i <= dc ? x : $urandom;
          in_q <= dc ? -x : $urandom;
        end
        in_valid <= dc | ($urandom % 2);
      end
      in_valid <= 1'b0;
    end
  endtask
  task ratio_run(input [11:0] c5, input [11:0] li, input [11:0] mi, input [5:0] s, input integer r);
    begin
      rst(2);
      wr(4'h9, c5);
      wr(4'h8, li);
      wr(4'h7, mi);
      wr(4'h6, s);
      outs = 0;
      stream(30, 1'b1, 18'h0_1000);
      repeat (60) @(posedge clk);
      check("out_count", r * 30, outs);
      check("dc_gain", 18'h0_1000, last_i);
      $display("test ratio %0d done", r);
    end
  endtask
  // Output watcher: compares each accepted sample with the oldest note while sb_on is set
  always @(posedge clk) begin
    if (!sys_rst && out_valid && out_ready) begin
      outs = outs + 1;
      last_i = out_i;
      if (sb_on && exp_q.size() == 0) check("empty_queue", 1, 0);
      else if (sb_on) check("out_iq", exp_q.pop_front(), {out_i, out_q});
    end
  end
  task tally_and_finish;
    begin
      $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #300000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    a = $urandom(99476);
    rst(10);
    for (a = 5; a < 11; a = a + 1) rd_chk(a[3:0], a == 6 ? 12'h004 : 12'h000);
    for (a = 5; a < 11; a = a + 1) wr(a[3:0], 12'hfff);
    for (a = 5; a < 11; a = a + 1) rd_chk(a[3:0], msk(a[3:0]));
    $display("test registers done");
    rst(2);
    stall_en <= 1'b1;
    sb_on = 1'b1;
    for (a = 0; a < 4; a = a + 1) begin
      sh = a == 3 ? 6'h20 : a;
      wr(4'h6, {6'h00, sh});
      stream(24, 1'b0, 18'h0_0000);
      repeat (40) @(posedge clk);
      check("queue_left", 0, exp_q.size());
    end
    sb_on = 1'b0;
    stall_en <= 1'b0;
    $display("test bypass done");
    ratio_run(12'h003, 12'h000, 12'h000, 6'h08, 4);
    ratio_run(12'h000, 12'h001, 12'h000, 6'h01, 2);
    ratio_run(12'h001, 12'h001, 12'h000, 6'h05, 4);
    ratio_run(12'h000, 12'h003, 12'h001, 6'h02, 2);
    tally_and_finish;
  end
endmodule // tb_cicic_chain
